// ### src/dacu_pkg.sv
// Purpose: shared constants and state type for the current-DAC update control
// Assumes: byte-wide register bus with page select, one system clock
// Notes:   control register reset value of the persistence bit depends on reset cause
package dacu_pkg;

  // register addresses and pages
  localparam logic [7:0] ADDR_WORD_LOW  = 8'h96;
  localparam logic [7:0] ADDR_WORD_HIGH = 8'h97;
  localparam logic [7:0] ADDR_CONTROL   = 8'hB9;
  localparam logic [7:0] PAGE_DAC0      = 8'h00;
  localparam logic [7:0] PAGE_DAC1      = 8'h0F;

  // control register and low data byte field positions
  localparam int CTL_EN_BIT  = 7;
  localparam int CTL_CM_MSB  = 6;
  localparam int CTL_CM_LSB  = 4;
  localparam int CTL_RP_BIT  = 2;
  localparam int CTL_OMD_MSB = 1;
  localparam int CTL_OMD_LSB = 0;
  localparam int LOW_FIELD_MSB = 7;
  localparam int LOW_FIELD_LSB = 6;

  // update source codes
  localparam logic [2:0] CM_TIMER0 = 3'h0;
  localparam logic [2:0] CM_TIMERB = 3'h1;
  localparam logic [2:0] CM_TIMER2 = 3'h2;
  localparam logic [2:0] CM_TIMER3 = 3'h3;
  localparam logic [2:0] CM_RISE   = 3'h4;
  localparam logic [2:0] CM_FALL   = 3'h5;
  localparam logic [2:0] CM_ANY    = 3'h6;
  localparam logic [2:0] CM_WRITE  = 3'h7;

  // range codes
  localparam logic [1:0] OMD_HALF_MA = 2'h0;
  localparam logic [1:0] OMD_ONE_MA  = 2'h1;

  // reset values
  localparam logic       EN_RESET   = 1'h0;
  localparam logic [2:0] CM_RESET   = CM_WRITE;
  localparam logic       RP_RESET   = 1'h0;
  localparam logic [1:0] OMD_RESET  = 2'h2;
  localparam logic [7:0] HIGH_RESET = 8'h00;
  localparam logic [1:0] LOW_RESET  = 2'h0;
  localparam logic [9:0] WORD_RESET = 10'h000;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  typedef struct packed {
    logic [7:0] high0;
    logic [1:0] low0;
    logic [9:0] out0;
    logic [7:0] high1;
    logic [1:0] low1;
    logic [9:0] out1;
    logic       en1;
    logic [2:0] cm1;
    logic       rp1;
    logic [1:0] omd1;
    logic [2:0] sync;
    logic [7:0] rdata;
  } dacu_state_t;

  typedef struct packed {
    logic t0;
    logic t1;
    logic t2;
    logic t3;
    logic t5;
  } dacu_timers_t;

endpackage

// ### src/dacu_current_dac_update_control.sv
// Purpose: data word, update scheduling and control for two current DACs
// Assumes: bus and timer inputs synchronous to ref_clk; arst_n is power-on reset
// Notes:   warm_reset is any other reset source, a one-cycle synchronous pulse
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Each DAC's high data byte holds word bits 9..2, fully readable and writable.
// - Each DAC's low data byte holds word bits 1..0 in its bits 7..6, left-justified.
// - Bits 5..0 of each low data byte read zero and ignore writes.
// - Update source codes 000..011 load the output on Timer 0, 5, 2 or 3 overflow.
// - Codes 100, 101, 110 load the output on a rising, falling or any strobe edge.
// - Code 111, the reset value, loads the output when the high byte is written.
// - With persistence clear, any reset clears the second DAC's enable.
// - With persistence set, non-power-on resets keep enable, configuration and output word.
// - The persistence bit is cleared by power-on reset or a control write, never by other resets.
// - Range field 00 gives 0.5 mA, 01 gives 1.0 mA, 1x gives 2.0 mA; reset selects 2.0 mA.
// - The second DAC decodes at 0xB9, 0x97, 0x96 on page F, the first at 0x97, 0x96 on page 0.
// - In timer or strobe modes both data bytes are held and copied only on the event.
// - In write mode a low byte write leaves the output unchanged until the next high byte write.
// - For the first DAC code 001 selects Timer 1 instead of Timer 5.
module dacu_current_dac_update_control
  import dacu_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         warm_reset,
  input  wire logic [7:0]   sfr_page,
  input  wire logic [7:0]   sfr_addr,
  input  wire logic         sfr_wr,
  input  wire logic         sfr_rd,
  input  wire logic [7:0]   sfr_wdata,
  output logic      [7:0]   sfr_rdata,
  input  wire dacu_timers_t timer_ovf,
  input  wire logic         conversion_strobe_pin,
  input  wire logic [2:0]   dac0_update_source,
  output logic      [9:0]   dac0_code,
  output logic      [9:0]   dac1_code,
  output logic              dac1_enable_bit,
  output logic      [1:0]   dac1_range_select
);

  //////////////////////////////////////////////////////////////////////////////
  // event selection

  dacu_state_t st;
  dacu_state_t next_st;

  function automatic logic pick_event(
    input logic [2:0] cm,
    input logic       tmr_b,
    input logic       rise,
    input logic       fall,
    input logic       t0,
    input logic       t2,
    input logic       t3
  );
    logic ev;
    ev = 1'b0;
    case (cm)
      CM_TIMER0: ev = t0;
      CM_TIMERB: ev = tmr_b;
      CM_TIMER2: ev = t2;
      CM_TIMER3: ev = t3;
      CM_RISE:   ev = rise;
      CM_FALL:   ev = fall;
      CM_ANY:    ev = rise | fall;
      default:   ev = 1'b0;
    endcase
    return ev;
  endfunction

  logic strobe_rise;
  logic strobe_fall;
  logic wr_low0;
  logic wr_high0;
  logic wr_low1;
  logic wr_high1;
  logic wr_ctl1;
  logic ev0;
  logic ev1;
  logic sel0;
  logic sel1;

  // sync[0] feeds only sync[1]; edges compare the settled stages
  assign strobe_rise = st.sync[1] & ~st.sync[2];
  assign strobe_fall = ~st.sync[1] & st.sync[2];

  assign sel0     = (sfr_page == PAGE_DAC0);
  assign sel1     = (sfr_page == PAGE_DAC1);
  assign wr_low0  = sfr_wr & sel0 & (sfr_addr == ADDR_WORD_LOW);
  assign wr_high0 = sfr_wr & sel0 & (sfr_addr == ADDR_WORD_HIGH);
  assign wr_low1  = sfr_wr & sel1 & (sfr_addr == ADDR_WORD_LOW);
  assign wr_high1 = sfr_wr & sel1 & (sfr_addr == ADDR_WORD_HIGH);
  assign wr_ctl1  = sfr_wr & sel1 & (sfr_addr == ADDR_CONTROL);

  assign ev0 = pick_event(dac0_update_source, timer_ovf.t1, strobe_rise, strobe_fall,
                          timer_ovf.t0, timer_ovf.t2, timer_ovf.t3);
  assign ev1 = pick_event(st.cm1, timer_ovf.t5, strobe_rise, strobe_fall,
                          timer_ovf.t0, timer_ovf.t2, timer_ovf.t3);

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_st = st;
    next_st.sync = {st.sync[1:0], conversion_strobe_pin};

    // events copy the held bytes present before this cycle's write
    if (ev0)
    begin
      next_st.out0 = {st.high0, st.low0};
    end
    if (ev1)
    begin
      next_st.out1 = {st.high1, st.low1};
    end

    if (wr_high0)
    begin
      next_st.high0 = sfr_wdata;
      if (dac0_update_source == CM_WRITE)
      begin
        next_st.out0 = {sfr_wdata, st.low0};
      end
    end
    if (wr_low0)
    begin
      next_st.low0 = sfr_wdata[LOW_FIELD_MSB:LOW_FIELD_LSB];
    end
    if (wr_high1)
    begin
      next_st.high1 = sfr_wdata;
      if (st.cm1 == CM_WRITE)
      begin
        next_st.out1 = {sfr_wdata, st.low1};
      end
    end
    if (wr_low1)
    begin
      next_st.low1 = sfr_wdata[LOW_FIELD_MSB:LOW_FIELD_LSB];
    end
    if (wr_ctl1)
    begin
      // bit 3 is simply not stored; persistence without enable is software's fault
      next_st.en1  = sfr_wdata[CTL_EN_BIT];
      next_st.cm1  = sfr_wdata[CTL_CM_MSB:CTL_CM_LSB];
      next_st.rp1  = sfr_wdata[CTL_RP_BIT];
      next_st.omd1 = sfr_wdata[CTL_OMD_MSB:CTL_OMD_LSB];
    end

    // register read, answered on the next edge
    if (sfr_rd)
    begin
      next_st.rdata = READ_ZERO;
      if (sel0 && sfr_addr == ADDR_WORD_HIGH)
      begin
        next_st.rdata = st.high0;
      end
      else if (sel0 && sfr_addr == ADDR_WORD_LOW)
      begin
        next_st.rdata = {st.low0, 6'h00};
      end
      else if (sel1 && sfr_addr == ADDR_WORD_HIGH)
      begin
        next_st.rdata = st.high1;
      end
      else if (sel1 && sfr_addr == ADDR_WORD_LOW)
      begin
        next_st.rdata = {st.low1, 6'h00};
      end
      else if (sel1 && sfr_addr == ADDR_CONTROL)
      begin
        next_st.rdata = {st.en1, st.cm1, 1'b0, st.rp1, st.omd1};
      end
    end

    // warm reset: the first DAC always reverts, the second only without persistence
    if (warm_reset)
    begin
      next_st.high0 = HIGH_RESET;
      next_st.low0  = LOW_RESET;
      next_st.out0  = WORD_RESET;
      next_st.rdata = READ_ZERO;
      if (!st.rp1)
      begin
        next_st.en1   = EN_RESET;
        next_st.cm1   = CM_RESET;
        next_st.omd1  = OMD_RESET;
        next_st.high1 = HIGH_RESET;
        next_st.low1  = LOW_RESET;
        next_st.out1  = WORD_RESET;
      end
      else
      begin
        next_st.en1  = st.en1;
        next_st.cm1  = st.cm1;
        next_st.omd1 = st.omd1;
        next_st.high1 = st.high1;
        next_st.low1  = st.low1;
        next_st.out1  = st.out1;
      end
      next_st.rp1 = st.rp1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st.high0 <= HIGH_RESET;
      st.low0  <= LOW_RESET;
      st.out0  <= WORD_RESET;
      st.high1 <= HIGH_RESET;
      st.low1  <= LOW_RESET;
      st.out1  <= WORD_RESET;
      st.en1   <= EN_RESET;
      st.cm1   <= CM_RESET;
      st.rp1   <= RP_RESET;
      st.omd1  <= OMD_RESET;
      st.sync  <= 3'h0;
      st.rdata <= READ_ZERO;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sfr_rdata         = st.rdata;
  assign dac0_code         = st.out0;
  assign dac1_code         = st.out1;
  assign dac1_enable_bit   = st.en1;
  assign dac1_range_select = st.omd1;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_high_byte_store: assert property (wr_high0 && !warm_reset |=> st.high0 == $past(sfr_wdata))
    else $error("high byte not stored");
  a_low_field_store: assert property (wr_low1 && !warm_reset |=> st.low1 == $past(sfr_wdata[7:6]))
    else $error("low field not stored");
  a_low_reads_zero: assert property (sfr_rd && sel1 && sfr_addr == ADDR_WORD_LOW && !warm_reset
                                    |=> sfr_rdata[5:0] == 6'h00 && sfr_rdata[7:6] == $past(st.low1))
    else $error("low byte read wrong");
  a_timer_update: assert property (st.cm1 == CM_TIMERB && timer_ovf.t5 && !wr_high1 && !warm_reset
                                  |=> dac1_code == $past({st.high1, st.low1}))
    else $error("timer overflow did not update");
  a_strobe_rise: assert property (st.cm1 == CM_RISE && !warm_reset && !wr_high1
                                  && $past(conversion_strobe_pin, 2) && !$past(conversion_strobe_pin, 3)
                                  |=> dac1_code == $past({st.high1, st.low1}))
    else $error("strobe edge did not update");
  a_write_update: assert property (wr_high1 && st.cm1 == CM_WRITE && !warm_reset
                                  |=> dac1_code == {$past(sfr_wdata), $past(st.low1)})
    else $error("high write did not update");
  a_low_holds: assert property (st.cm1 == CM_WRITE && !wr_high1 && !warm_reset
                                |=> $stable(dac1_code))
    else $error("output changed without high write");
  a_reset_disable: assert property (warm_reset && !st.rp1 |=> !dac1_enable_bit)
    else $error("enable survived reset");
  a_persist_keep: assert property (warm_reset && st.rp1
                                  |=> $stable(dac1_enable_bit) && $stable(dac1_code))
    else $error("persistent state lost");
  a_rp_sticky: assert property (warm_reset |=> $stable(st.rp1))
    else $error("persistence bit changed on reset");
  a_ctl_reserved: assert property (sfr_rd && sel1 && sfr_addr == ADDR_CONTROL
                                   |=> sfr_rdata[3] == 1'b0)
    else $error("reserved bit read nonzero");
  a_dac0_write: assert property (
    wr_high0 && dac0_update_source == CM_WRITE && !warm_reset
    |=> dac0_code == {$past(sfr_wdata), $past(st.low0)})
    else $error("first dac high write did not update");
  a_dac0_timer: assert property (
    dac0_update_source == CM_TIMERB && timer_ovf.t1 && !warm_reset
    |=> dac0_code == $past({st.high0, st.low0}))
    else $error("first dac timer 1 did not update");
  a_timer_hold: assert property (
    st.cm1 == CM_TIMER0 && !timer_ovf.t0 && !warm_reset |=> $stable(dac1_code))
    else $error("output moved without its timer");
  a_strobe_single: assert property (strobe_rise |=> !strobe_rise)
    else $error("strobe edge gave a long pulse");
  a_range_store: assert property (
    wr_ctl1 && !warm_reset |=> dac1_range_select == $past(sfr_wdata[CTL_OMD_MSB:CTL_OMD_LSB]))
    else $error("range field not stored");

  c_timer_update: cover property (st.cm1 == CM_TIMER0 && timer_ovf.t0);
  c_any_edge: cover property (st.cm1 == CM_ANY && strobe_fall);
  c_persist_reset: cover property (warm_reset && st.rp1 && st.en1);
  c_write_update: cover property (wr_low1 ##2 wr_high1);

endmodule

`default_nettype wire

// ### test/dacu_cpu_model.sv
// Purpose: cpu register bus, timer overflow and strobe pin model
// Assumes: each task is entered 1 ns after a rising edge
// Notes:   idle write data shows the inverse of the last value
`timescale 1ns/100ps
`default_nettype none
module dacu_cpu_model
  import dacu_pkg::*;
(
  input  wire logic         ref_clk,
  output logic      [7:0]   sfr_page,
  output logic      [7:0]   sfr_addr,
  output logic              sfr_wr,
  output logic              sfr_rd,
  output logic      [7:0]   sfr_wdata,
  input  wire logic [7:0]   sfr_rdata,
  output dacu_timers_t      timer_ovf,
  output logic              conversion_strobe_pin
);
  initial
  begin
    {sfr_page, sfr_addr, sfr_wr, sfr_rd, sfr_wdata} = '0;
    timer_ovf = '0;
    conversion_strobe_pin = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // software never sets persistence without enable
  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] d);
    {sfr_page, sfr_addr, sfr_wr} = {pg, ad, 1'b1};
    sfr_wdata = (ad == ADDR_CONTROL && d[CTL_RP_BIT]) ? (d | 8'h80) : d;
    @(posedge ref_clk);
    #1;
    sfr_wr = 1'b0;
    sfr_wdata = ~sfr_wdata;
    // idle edge, so a following call never re-raises the strobe in this time step
    @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] d);
    {sfr_page, sfr_addr, sfr_rd} = {pg, ad, 1'b1};
    @(posedge ref_clk);
    #1;
    sfr_rd = 1'b0;
    @(posedge ref_clk);
    #1;
    d = sfr_rdata;
  endtask
  task automatic pulse(input logic [4:0] m);
    timer_ovf = dacu_timers_t'(m);
    @(posedge ref_clk);
    #1;
    timer_ovf = '0;
  endtask
  task automatic pin(input logic v);
    conversion_strobe_pin = v;
  endtask
endmodule
`default_nettype wire

// ### test/dacu_current_dac_update_control_test.sv
// Purpose: self-checking bench for the current-DAC update control
// Assumes: cpu model drives bus, timers and strobe; bench drives resets
// Notes:   outputs are sampled one or more cycles after they settle
`timescale 1ns/100ps
`default_nettype none
module dacu_current_dac_update_control_test
  import dacu_pkg::*;
;
  logic         ref_clk;
  logic         arst_n;
  logic         warm_reset;
  logic [7:0]   sfr_page;
  logic [7:0]   sfr_addr;
  logic         sfr_wr;
  logic         sfr_rd;
  logic [7:0]   sfr_wdata;
  logic [7:0]   sfr_rdata;
  dacu_timers_t timer_ovf;
  logic         conversion_strobe_pin;
  logic [2:0]   dac0_update_source;
  logic [9:0]   dac0_code;
  logic [9:0]   dac1_code;
  logic         dac1_enable_bit;
  logic [1:0]   dac1_range_select;
  logic [9:0]   last;
  int           fails = 0;
  int           checks = 0;
  int           cycles = 0;

  dacu_current_dac_update_control i_dut (.ref_clk, .arst_n, .warm_reset, .sfr_page, .sfr_addr,
    .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .timer_ovf, .conversion_strobe_pin,
    .dac0_update_source, .dac0_code, .dac1_code, .dac1_enable_bit, .dac1_range_select);
  dacu_cpu_model i_cpu (.ref_clk, .sfr_page, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .timer_ovf, .conversion_strobe_pin);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic rchk(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] v;
    i_cpu.rd(pg, ad, v);
    chk("register read", 16'(v), 16'(exp));
  endtask
  task automatic wword(input logic [7:0] pg, input logic [9:0] w);
    i_cpu.wr(pg, ADDR_WORD_LOW, {w[1:0], 6'h2A});
    i_cpu.wr(pg, ADDR_WORD_HIGH, w[9:2]);
  endtask
  task automatic warm;
    warm_reset = 1'b1;
    tick(1);
    warm_reset = 1'b0;
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(PAGE_DAC1, ADDR_CONTROL, 8'h72);
    rchk(PAGE_DAC1, ADDR_WORD_HIGH, 8'h00);
    rchk(PAGE_DAC0, ADDR_WORD_LOW, 8'h00);
    rchk(PAGE_DAC0, ADDR_CONTROL, 8'h00);
    rchk(8'h03, ADDR_WORD_HIGH, 8'h00);
    chk("range", 16'(dac1_range_select), 16'h2);
    chk("enable", 16'(dac1_enable_bit), 16'h0);
  endtask
  task automatic t_write;
    i_cpu.wr(PAGE_DAC1, ADDR_WORD_LOW, 8'hFF);
    tick(1);
    chk("dac1 code", 16'(dac1_code), 16'h000);
    rchk(PAGE_DAC1, ADDR_WORD_LOW, 8'hC0);
    i_cpu.wr(PAGE_DAC1, ADDR_WORD_HIGH, 8'hAB);
    tick(1);
    chk("dac1 code", 16'(dac1_code), 16'h2AF);
    rchk(PAGE_DAC1, ADDR_WORD_HIGH, 8'hAB);
    wword(PAGE_DAC0, 10'h049);
    tick(1);
    chk("dac0 code", 16'(dac0_code), 16'h049);
    chk("dac1 code", 16'(dac1_code), 16'h2AF);
    last = 10'h2AF;
  endtask
  task automatic t_timer;
    logic [4:0] m;
    logic [9:0] w;
    for (int c = 0; c < 4; c++)
    begin
      m = (c == 0) ? 5'h10 : (c == 1) ? 5'h01 : (c == 2) ? 5'h04 : 5'h02;
      w = 10'(c * 97 + 5);
      i_cpu.wr(PAGE_DAC1, ADDR_CONTROL, {1'b1, 3'(c), 2'b10, 2'(c)});
      rchk(PAGE_DAC1, ADDR_CONTROL, {1'b1, 3'(c), 2'b00, 2'(c)});
      chk("range", 16'(dac1_range_select), 16'(c));
      wword(PAGE_DAC1, w);
      i_cpu.pulse(~m);
      tick(2);
      chk("dac1 held", 16'(dac1_code), 16'(last));
      i_cpu.pulse(m);
      tick(2);
      chk("dac1 timer", 16'(dac1_code), 16'(w));
      last = w;
    end
    // first dac: code 001 follows timer 1, not timer 5
    dac0_update_source = CM_TIMERB;
    i_cpu.wr(PAGE_DAC0, ADDR_WORD_HIGH, 8'h55);
    i_cpu.pulse(5'h01);
    tick(2);
    chk("dac0 held", 16'(dac0_code), 16'h049);
    i_cpu.pulse(5'h08);
    tick(2);
    chk("dac0 timer", 16'(dac0_code), 16'h155);
  endtask
  task automatic t_strobe;
    logic [9:0] w;
    for (int c = 4; c < 7; c++)
    begin
      i_cpu.wr(PAGE_DAC1, ADDR_CONTROL, {1'b1, 3'(c), 4'h2});
      for (int e = 1; e >= 0; e--)
      begin
        w = 10'(c * 61 + e * 300);
        wword(PAGE_DAC1, w);
        tick(2);
        chk("dac1 held", 16'(dac1_code), 16'(last));
        i_cpu.pin(e[0]);
        tick(6);
        if ((e == 1 && c != 5) || (e == 0 && c != 4))
          last = w;
        chk("dac1 strobe", 16'(dac1_code), 16'(last));
      end
    end
  endtask
  task automatic t_warm;
    i_cpu.wr(PAGE_DAC1, ADDR_CONTROL, 8'h86);
    warm();
    chk("enable kept", 16'(dac1_enable_bit), 16'h1);
    chk("code kept", 16'(dac1_code), 16'(last));
    rchk(PAGE_DAC1, ADDR_CONTROL, 8'h86);
    i_cpu.wr(PAGE_DAC1, ADDR_CONTROL, 8'h82);
    warm();
    chk("enable", 16'(dac1_enable_bit), 16'h0);
    rchk(PAGE_DAC1, ADDR_CONTROL, 8'h72);
    i_cpu.wr(PAGE_DAC1, ADDR_CONTROL, 8'h86);
    arst_n = 1'b0;
    tick(1);
    arst_n = 1'b1;
    tick(1);
    rchk(PAGE_DAC1, ADDR_CONTROL, 8'h72);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    arst_n = 1'b0;
    warm_reset = 1'b0;
    dac0_update_source = CM_WRITE;
    last = 10'h000;
    tick(8);
    arst_n = 1'b1;
    tick(1);
    t_reset();
    t_write();
    t_timer();
    t_strobe();
    t_warm();
    summarize();
  end
endmodule
`default_nettype wire
